// File: verilog/spcs_top.sv
// Position compare and status logic with an AXI4-Lite register slave.
`timescale 1ns/1ps
module spcs_top #(
    parameter int MAX_POS_BITS = 32
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [spcs_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [spcs_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic link_clk,
    input wire logic link_data,
    output logic irq
);
    import spcs_pkg::*;

    localparam int SHIFT_W = MAX_POS_BITS + STS_W;

    if (MAX_POS_BITS < 1 || MAX_POS_BITS > 32) begin : g_bad_bits
        $error("MAX_POS_BITS must lie in 1 to 32");
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] apply_strb(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] strb
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i])
                r[8*i +: 8] = new_v[8*i +: 8];
        end
        return r;
    endfunction

    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        return (a[1:0] == 2'h0) && (a <= OFS_LAST);
    endfunction

    function automatic logic [31:0] width_mask(input logic [5:0] n);
        logic [31:0] m;
        m = 32'hFFFF_FFFF;
        if (n < 6'd32)
            m = (32'h0000_0001 << n) - 32'h0000_0001;
        return m;
    endfunction

    function automatic logic [1:0] chan_cmp(
        input logic on,
        input logic [31:0] p,
        input logic [31:0] c
    );
        return {on && (p >= c), on && (p == c)};
    endfunction

    function automatic logic latch_next(
        input logic on,
        input logic clr,
        input logic hit,
        input logic old
    );
        return on && !clr && (old || hit);
    endfunction

    function automatic logic went_high(input logic now, input logic was);
        return now && !was;
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic awdone;
        logic [ADDR_W-1:0] awaddr;
        logic wdone;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [31:0] ctrl;
        logic [31:0] cfg;
        logic [31:0] cmp_a;
        logic [31:0] cmp_b;
        logic [31:0] upper;
        logic [31:0] lower;
        logic [31:0] pos;
        logic [STS_W-1:0] enc_sts;
        logic pos_valid;
        logic match_a;
        logic match_b;
        logic up;
        logic down;
        logic sig_fault;
        logic par_prev;
        logic limit_prev;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_mask;
        logic irq_out;
    } spcs_state_t;

    spcs_state_t s;
    spcs_state_t next_s;

    logic frame_done;
    logic [SHIFT_W-1:0] frame_word;
    logic [CNT_W-1:0] frame_count;
    logic line_low;
    logic rx_enable;

    // ****************************************************************
    // Derived status
    // ****************************************************************
    logic [5:0] pos_bits;
    logic sts_in_frame;
    logic par_fault;
    logic en_a;
    logic en_b;
    logic eq_a;
    logic eq_b;
    logic above_a;
    logic above_b;
    logic over;
    logic under;
    logic halted;
    logic [STS_W-1:0] enc_status;
    logic diag;
    logic [31:0] status_word;

    always_comb begin
        pos_bits = s.cfg[CFG_BITS_LSB +: 6];
        sts_in_frame = s.cfg[CFG_STS_IN_FRAME];
        par_fault = (pos_bits == 6'h00) ||
            (32'(pos_bits) > 32'(MAX_POS_BITS)) ||
            (s.lower > s.upper);
        halted = s.ctrl[CTRL_STOP];
        en_a = s.ctrl[CTRL_EN_A];
        en_b = s.ctrl[CTRL_EN_B];
        {above_a, eq_a} = chan_cmp(en_a && s.pos_valid, s.pos,
            s.cmp_a);
        {above_b, eq_b} = chan_cmp(en_b && s.pos_valid, s.pos,
            s.cmp_b);
        over = s.pos_valid && (s.pos > s.upper);
        under = s.pos_valid && (s.pos < s.lower);
        enc_status = s.enc_sts |
            {2'h0, par_fault, s.sig_fault};
        diag = |(enc_status & s.cfg[CFG_STS_EN_LSB +: STS_W]);
        status_word = 32'h0000_0000;
        status_word[ST_ABOVE_A] = above_a;
        status_word[ST_EQ_A] = eq_a;
        status_word[ST_LATCH_A] = s.match_a;
        status_word[ST_ABOVE_B] = above_b;
        status_word[ST_EQ_B] = eq_b;
        status_word[ST_LATCH_B] = s.match_b;
        status_word[ST_UP] = s.up;
        status_word[ST_DOWN] = s.down;
        status_word[ST_OVER] = over;
        status_word[ST_UNDER] = under;
        status_word[ST_HALT] = halted;
        status_word[ST_DIAG] = diag;
        status_word[ST_ENC_LSB +: STS_W] = enc_status;
        status_word[ST_SIG_FAULT] = s.sig_fault;
        status_word[ST_PAR_FAULT] = par_fault;
        status_word[ST_POS_VALID] = s.pos_valid;
    end

    assign rx_enable = !halted && !par_fault;

    // ****************************************************************
    // Link receiver
    // ****************************************************************
    spcs_link_rx #(
        .SHIFT_W(SHIFT_W)
    ) u_rx (
        .aclk(aclk),
        .aresetn(aresetn),
        .link_clk(link_clk),
        .link_data(link_data),
        .rx_enable(rx_enable),
        .frame_done(frame_done),
        .frame_word(frame_word),
        .frame_count(frame_count),
        .line_low(line_low)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    logic [CNT_W-1:0] expect_cnt;
    logic [SHIFT_W-1:0] shifted;
    logic [31:0] new_pos;
    logic good_frame;
    logic [IRQ_W-1:0] w1c;
    logic [IRQ_W-1:0] events;
    logic [31:0] rd_val;

    always_comb begin
        next_s = s;
        w1c = '0;
        events = '0;
        rd_val = 32'h0000_0000;
        // Write channel: address and data are taken in either order.
        if (s_axi_awvalid && s_axi_awready) begin
            next_s.awdone = 1'b1;
            next_s.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_s.wdone = 1'b1;
            next_s.wdata = s_axi_wdata;
            next_s.wstrb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready)
            next_s.bvalid = 1'b0;
        if (s.awdone && s.wdone && !s.bvalid) begin
            next_s.awdone = 1'b0;
            next_s.wdone = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = addr_ok(s.awaddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (s.awaddr)
                OFS_CTRL: next_s.ctrl = apply_strb(s.ctrl, s.wdata, s.wstrb);
                OFS_CFG: next_s.cfg = apply_strb(s.cfg, s.wdata, s.wstrb);
                OFS_CMP_A:
                    next_s.cmp_a = apply_strb(s.cmp_a, s.wdata, s.wstrb);
                OFS_CMP_B:
                    next_s.cmp_b = apply_strb(s.cmp_b, s.wdata, s.wstrb);
                OFS_UPPER:
                    next_s.upper = apply_strb(s.upper, s.wdata, s.wstrb);
                OFS_LOWER:
                    next_s.lower = apply_strb(s.lower, s.wdata, s.wstrb);
                OFS_IRQ_ST:
                    w1c = s.wstrb[0] ? s.wdata[IRQ_W-1:0] : '0;
                OFS_IRQ_MASK: begin
                    if (s.wstrb[0])
                        next_s.irq_mask = s.wdata[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // Read channel answers one cycle after the address is taken.
        if (s.rvalid && s_axi_rready)
            next_s.rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready) begin
            unique case (s_axi_araddr)
                OFS_CTRL: rd_val = s.ctrl;
                OFS_CFG: rd_val = s.cfg;
                OFS_CMP_A: rd_val = s.cmp_a;
                OFS_CMP_B: rd_val = s.cmp_b;
                OFS_UPPER: rd_val = s.upper;
                OFS_LOWER: rd_val = s.lower;
                OFS_POS: rd_val = s.pos;
                OFS_STATUS: rd_val = status_word;
                OFS_IRQ_ST: rd_val = 32'(s.irq_st);
                OFS_IRQ_MASK: rd_val = 32'(s.irq_mask);
                default: rd_val = 32'h0000_0000;
            endcase
            next_s.rvalid = 1'b1;
            next_s.rdata = rd_val;
            next_s.rresp = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        // New position from a finished frame.
        expect_cnt = CNT_W'(pos_bits) + (sts_in_frame ? CNT_W'(STS_W) : '0);
        shifted = sts_in_frame ? (frame_word >> STS_W) : frame_word;
        new_pos = 32'(shifted) & width_mask(pos_bits);
        good_frame = frame_done && (frame_count == expect_cnt);
        if (good_frame) begin
            next_s.pos = new_pos;
            next_s.pos_valid = 1'b1;
            next_s.sig_fault = 1'b0;
            next_s.enc_sts = sts_in_frame ? frame_word[STS_W-1:0] : '0;
            if (s.pos_valid) begin
                next_s.up = new_pos > s.pos;
                next_s.down = new_pos < s.pos;
            end
        end else if ((frame_done && !good_frame) || line_low) begin
            next_s.sig_fault = 1'b1;
        end
        // Sticky match latches; a clear request overrides a match.
        next_s.match_a = latch_next(en_a, s.ctrl[CTRL_CLR_A], eq_a,
            s.match_a);
        next_s.match_b = latch_next(en_b, s.ctrl[CTRL_CLR_B], eq_b,
            s.match_b);
        // Interrupt events; a new event wins over its write-one clear.
        events[IRQ_MATCH_A] = went_high(next_s.match_a, s.match_a);
        events[IRQ_MATCH_B] = went_high(next_s.match_b, s.match_b);
        events[IRQ_NEW_POS] = good_frame;
        events[IRQ_SIG] = went_high(next_s.sig_fault, s.sig_fault);
        events[IRQ_PAR] = went_high(par_fault, s.par_prev);
        events[IRQ_LIMIT] = went_high(over || under, s.limit_prev);
        next_s.par_prev = par_fault;
        next_s.limit_prev = over || under;
        next_s.irq_st = (s.irq_st & ~w1c) | events;
        next_s.irq_out = |(next_s.irq_st & next_s.irq_mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.ctrl <= CTRL_RESET;
            s.cfg <= CFG_RESET;
            s.cmp_a <= CMP_RESET;
            s.cmp_b <= CMP_RESET;
            s.upper <= UPPER_RESET;
            s.lower <= LOWER_RESET;
            s.irq_st <= IRQ_RESET;
            s.irq_mask <= IRQ_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign s_axi_awready = !s.awdone && !s.bvalid;
    assign s_axi_wready = !s.wdone && !s.bvalid;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign irq = s.irq_out;
endmodule // spcs_top

// File: pkg/spcs_pkg.sv
// Constants, field layout and timing of the position compare status block.
package spcs_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CFG = 8'h04;
    localparam logic [7:0] OFS_CMP_A = 8'h08;
    localparam logic [7:0] OFS_CMP_B = 8'h0C;
    localparam logic [7:0] OFS_UPPER = 8'h10;
    localparam logic [7:0] OFS_LOWER = 8'h14;
    localparam logic [7:0] OFS_POS = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_IRQ_ST = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
    localparam logic [7:0] OFS_LAST = 8'h24;
    // ****************************************************************
    // Control and configuration fields
    // ****************************************************************
    localparam int CTRL_STOP = 0;
    localparam int CTRL_EN_A = 1;
    localparam int CTRL_EN_B = 2;
    localparam int CTRL_CLR_A = 3;
    localparam int CTRL_CLR_B = 4;
    localparam int CFG_BITS_LSB = 0;
    localparam int CFG_STS_IN_FRAME = 8;
    localparam int CFG_STS_EN_LSB = 12;
    localparam int STS_W = 4;
    // ****************************************************************
    // Status and interrupt fields
    // ****************************************************************
    localparam int ST_ABOVE_A = 0;
    localparam int ST_EQ_A = 1;
    localparam int ST_LATCH_A = 2;
    localparam int ST_ABOVE_B = 3;
    localparam int ST_EQ_B = 4;
    localparam int ST_LATCH_B = 5;
    localparam int ST_UP = 6;
    localparam int ST_DOWN = 7;
    localparam int ST_OVER = 8;
    localparam int ST_UNDER = 9;
    localparam int ST_HALT = 10;
    localparam int ST_DIAG = 11;
    localparam int ST_ENC_LSB = 12;
    localparam int ST_SIG_FAULT = 16;
    localparam int ST_PAR_FAULT = 17;
    localparam int ST_POS_VALID = 18;
    localparam int IRQ_W = 6;
    localparam int IRQ_MATCH_A = 0;
    localparam int IRQ_MATCH_B = 1;
    localparam int IRQ_NEW_POS = 2;
    localparam int IRQ_SIG = 3;
    localparam int IRQ_PAR = 4;
    localparam int IRQ_LIMIT = 5;
    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CFG_RESET = 32'h0000_0019;
    localparam logic [31:0] CMP_RESET = 32'h0000_0000;
    localparam logic [31:0] UPPER_RESET = 32'hFFFF_FFFF;
    localparam logic [31:0] LOWER_RESET = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 6'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int LINK_GAP_NS = 2000;
    localparam int LINK_GAP_CYCLES =
        (LINK_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_W = 16;
    localparam int CNT_W = 7;
endpackage

// File: verilog/spcs_link_rx.sv
// Frame receiver for the synchronous serial encoder link.
`timescale 1ns/1ps
module spcs_link_rx #(
    parameter int SHIFT_W = 36
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic link_clk,
    input wire logic link_data,
    input wire logic rx_enable,
    output logic frame_done,
    output logic [SHIFT_W-1:0] frame_word,
    output logic [spcs_pkg::CNT_W-1:0] frame_count,
    output logic line_low
);
    import spcs_pkg::*;

    if (SHIFT_W < 2 || SHIFT_W >= (1 << CNT_W)) begin : g_bad_shift
        $error("SHIFT_W out of range");
    end

    typedef struct packed {
        logic clk_meta;
        logic clk_sync;
        logic clk_prev;
        logic dat_meta;
        logic dat_sync;
        logic [SHIFT_W-1:0] shift;
        logic [CNT_W-1:0] count;
        logic [GAP_W-1:0] gap;
        logic done;
        logic [SHIFT_W-1:0] word;
        logic [CNT_W-1:0] cnt_out;
        logic low;
    } spcs_rx_t;

    localparam logic [GAP_W-1:0] GAP_END = GAP_W'(LINK_GAP_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

    spcs_rx_t s;
    spcs_rx_t next_s;

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.clk_meta = link_clk;
        next_s.clk_sync = s.clk_meta;
        next_s.clk_prev = s.clk_sync;
        next_s.dat_meta = link_data;
        next_s.dat_sync = s.dat_meta;
        if (!rx_enable) begin
            next_s.count = '0;
            next_s.gap = '0;
            next_s.low = 1'b0;
        end else if (!s.clk_sync && s.clk_prev) begin
            next_s.shift = {s.shift[SHIFT_W-2:0], s.dat_sync};
            if (s.count != CNT_MAX)
                next_s.count = s.count + 1'b1;
            next_s.gap = '0;
            next_s.low = 1'b0;
        end else if (s.count != '0) begin
            next_s.gap = s.gap + 1'b1;
            if (s.gap == GAP_END) begin
                next_s.done = 1'b1;
                next_s.word = s.shift;
                next_s.cnt_out = s.count;
                next_s.count = '0;
                next_s.gap = '0;
            end
        end else if (!s.dat_sync) begin
            if (s.gap == GAP_END)
                next_s.low = 1'b1;
            else
                next_s.gap = s.gap + 1'b1;
        end else begin
            next_s.gap = '0;
            next_s.low = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            s <= '0;
        else
            s <= next_s;
    end

    assign frame_done = s.done;
    assign frame_word = s.word;
    assign frame_count = s.cnt_out;
    assign line_low = s.low;
endmodule // spcs_link_rx

// File: tb/spcs_encoder_model.sv
// Encoder model that shifts position frames onto the serial link.
`timescale 1ns/1ps
module spcs_encoder_model (
    output logic link_clk,
    output logic link_data
);
    // ************************************************************
    // Frame output
    // ************************************************************
    initial begin
        link_clk = 1'b1;
        link_data = 1'b1;
    end
    // Sends the lowest n bits MSB first, one per falling clock edge.
    task automatic send(input logic [31:0] v, input int n);
        #3;
        for (int i = n - 1; i >= 0; i--) begin
            link_data = v[i];
            #40 link_clk = 1'b0;
            #40 link_clk = 1'b1;
        end
        #40 link_data = 1'b1;
    endtask
    task automatic cut(input int t);
        link_data = 1'b0;
        #t link_data = 1'b1;
    endtask
endmodule // spcs_encoder_model

// File: tb/spcs_top_assertions.sv
// Port checks of the register bus and interrupt of the block.
`timescale 1ns/1ps
module spcs_top_assertions #(
    parameter int MAX_POS_BITS = 32
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic irq
);
    // ************************************************************
    // Properties
    // ************************************************************
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_b_blocks;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_b_blocks: assert property (p_b_blocks) else $error("write ready early");
    property p_r_blocks;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_r_blocks: assert property (p_r_blocks) else $error("read ready early");
    property p_r_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_answer: assert property (p_r_answer) else $error("read answer late");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_r_done;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_done: assert property (p_r_done) else $error("read answer repeated");
    property p_reset_quiet;
        $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs busy after reset");
    property p_err_zero;
        s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("error read not zero");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
    c_irq: cover property ($rose(irq));
endmodule // spcs_top_assertions
bind spcs_top spcs_top_assertions #(.MAX_POS_BITS(MAX_POS_BITS))
    spcs_top_assertions_inst (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .irq);

// File: tb/spcs_top_tb.sv
// Self-checking bench of the position compare status block.
`timescale 1ns/1ps
module spcs_top_tb;
    import spcs_pkg::*;
    // ************************************************************
    // Signals and helpers
    // ************************************************************
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic link_clk, link_data, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, en = '0, clr = '0, resp;
    logic [31:0] rdat, ca, cb, up, lo, pv = '0, p;
    logic la = 0, lb = 0, hv = 0, fu = 0, fd = 0, halt = 0, sig = 0, par = 0;
    logic [3:0] dm = '0;
    int miscompares = 0, cmp_count = 0;
    always #5 aclk = ~aclk;
    spcs_top spcs_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_clk, .link_data,
        .irq);
    spcs_encoder_model spcs_encoder_model_inst (.link_clk, .link_data);
    task automatic summarize;
        $display("mismatches %0d compares %0d", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: %h not %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        logic ta, tw, tr, dn;
        n = 0;
        dn = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        while (!dn && n < 99) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tr = s_axi_arvalid && s_axi_arready;
            dn = w ? s_axi_bvalid : s_axi_rvalid;
            resp = w ? s_axi_bresp : s_axi_rresp;
            rdat = s_axi_rdata;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tr) s_axi_arvalid <= 1'b0;
            if (dn) s_axi_bready <= 1'b0;
            if (dn) s_axi_rready <= 1'b0;
            n++;
        end
        if (!dn) begin
            miscompares++;
            summarize;
        end
    endtask
    function automatic logic [31:0] st();
        logic [3:0] ec;
        ec = {2'b00, par, sig};
        st = '0;
        if (hv) begin
            st[5:0] = {lb, en[1] && pv == cb, en[1] && pv >= cb,
                       la, en[0] && pv == ca, en[0] && pv >= ca};
            st[9:6] = {pv < lo, pv > up, fd, fu};
        end
        st[17:10] = {par, sig, ec, |(dm & ec), halt};
        st[18] = hv;
    endfunction
    task automatic upd;
        la = en[0] && !clr[0] && (la || (hv && pv == ca));
        lb = en[1] && !clr[1] && (lb || (hv && pv == cb));
    endtask
    task automatic cst;
        bus(1'b0, OFS_STATUS, '0);
        chk({13'h0, rdat[18:0]}, st());
    endtask
    task automatic ctl(input logic [4:0] v);
        bus(1'b1, OFS_CTRL, {27'h0, v});
        {clr, en, halt} = v;
        upd;
        cst;
    endtask
    task automatic wirq;
        int n;
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (irq !== 1'b1 && n < 2000);
        chk({31'h0, irq}, 32'h1);
        if (irq !== 1'b1) summarize;
        @(posedge aclk);
        bus(1'b0, OFS_IRQ_ST, '0);
        bus(1'b1, OFS_IRQ_ST, rdat);
        @(negedge aclk);
        chk({31'h0, irq}, 32'h0);
        @(posedge aclk);
    endtask
    task automatic frame(input logic [31:0] v, input int nb);
        spcs_encoder_model_inst.send(v, nb);
        wirq;
        sig = (nb != 25);
        if (!sig) begin
            fu = hv && v > pv;
            fd = hv && v < pv;
            hv = 1'b1;
            pv = v;
        end
        upd;
        bus(1'b0, OFS_POS, '0);
        chk(rdat, pv);
        cst;
    endtask
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        void'($urandom(32'hD795EBFB));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        bus(1'b0, OFS_CFG, '0);
        chk(rdat, CFG_RESET);
        bus(1'b0, OFS_UPPER, '0);
        chk(rdat, UPPER_RESET);
        cst;
        bus(1'b0, 8'h28, '0);
        chk({rdat[29:0], resp}, {30'h0, RESP_SLVERR});
        ca = $urandom & 32'h1FF_FFFF;
        cb = $urandom & 32'h1FF_FFFF;
        up = 32'h100_0000;
        lo = 32'h1000;
        bus(1'b1, OFS_CMP_A, ca);
        bus(1'b1, OFS_CMP_B, cb);
        bus(1'b1, OFS_UPPER, up);
        bus(1'b1, OFS_LOWER, lo);
        bus(1'b1, OFS_IRQ_MASK, 32'h1C);
        frame($urandom & 32'h1FF_FFFF, 25);
        ctl(5'h06);
        for (int i = 0; i < 12; i++) begin
            p = $urandom & 32'h1FF_FFFF;
            case (i)
                2: p = ca - 1;
                3: p = ca;
                5: p = cb;
                7: p = pv;
                8: p = up;
                9: p = up + 1;
                10: p = lo - 1;
                11: p = ca;
                default: ;
            endcase
            frame(p, 25);
        end
        ctl(5'h1E);
        ctl(5'h06);
        ctl(5'h00);
        ctl(5'h06);
        ctl(5'h07);
        spcs_encoder_model_inst.send(32'h5, 25);
        repeat (400) @(posedge aclk);
        cst;
        ctl(5'h06);
        dm = 4'h1;
        bus(1'b1, OFS_CFG, 32'h1019);
        frame(32'h5, 20);
        frame(32'h5, 25);
        spcs_encoder_model_inst.cut(2500);
        wirq;
        sig = 1'b1;
        cst;
        frame(32'h5, 25);
        lo = 32'h200_0000;
        par = 1'b1;
        bus(1'b1, OFS_LOWER, lo);
        wirq;
        cst;
        lo = 32'h1000;
        par = 1'b0;
        bus(1'b1, OFS_LOWER, lo);
        cst;
        summarize;
    end
endmodule // spcs_top_tb
